// *** arcd_pkg.sv ***
// Package: command word layout, register codes and configuration field layout
package arcd_pkg;

    // Command word field positions
    localparam int CMD_WR_BIT      = 15;
    localparam int CMD_SEL_HI      = 14;
    localparam int CMD_SEL_LO      = 9;
    localparam int CMD_DATA_HI     = 8;
    localparam int CMD_STACK_BIT   = 14;

    // Lower register-select codes with the stack bit clear
    localparam logic [4:0] SEL_CONV    = 5'h00;
    localparam logic [4:0] SEL_RSVD    = 5'h01;
    localparam logic [4:0] SEL_CONFIG  = 5'h02;
    localparam logic [4:0] SEL_CHANNEL = 5'h03;
    localparam logic [4:0] SEL_RANGE_FIRST = 5'h04;
    localparam logic [4:0] SEL_RANGE_LAST  = 5'h07;
    localparam logic [4:0] SEL_STATUS  = 5'h08;

    // Configuration register address, reset value and field positions
    localparam logic [5:0] ADDR_ACQUISITION_CONFIG = 6'h02;
    localparam logic [8:0] CONFIG_RESET            = 9'h000;
    localparam int CFG_RSVD_BIT  = 8;
    localparam int CFG_SELF_DETECT_FAIL_FLAG_BIT  = 7;
    localparam int CFG_BURST_BIT = 6;
    localparam int CFG_SEQ_BIT   = 5;
    localparam int CFG_OS_HI     = 4;
    localparam int CFG_OS_LO     = 2;
    localparam int CFG_STAT_BIT  = 1;
    localparam int CFG_CRC_BIT   = 0;
    localparam logic [2:0] OS_DISABLED = 3'h0;

    // Sequencer stack depth
    localparam int STACK_LAYERS = 32;

    // Decoded command word
    typedef struct packed {
        logic       write_not_read;
        logic [5:0] register_select;
        logic [8:0] data;
    } arcd_cmd_s;

    // Writable configuration fields
    typedef struct packed {
        logic       burst_enable_bit;
        logic       sequencer_enable_bit;
        logic [2:0] oversample_ratio;
        logic       status_append_enable;
        logic       checksum_append_enable;
    } arcd_cfg_s;

    // Register write forwarded to storage outside this block
    typedef struct packed {
        logic       valid;
        logic [5:0] register_select;
        logic [8:0] data;
    } arcd_wr_s;

    // Sequencer and readout states
    typedef enum logic [1:0] {
        ARCD_SEQ_IDLE,
        ARCD_SEQ_CONVERT
    } arcd_seq_e;

    typedef enum logic [1:0] {
        ARCD_RD_REG,
        ARCD_RD_CONV_A,
        ARCD_RD_CONV_B,
        ARCD_RD_STATUS
    } arcd_rd_e;

endpackage

// *** arcd_decoder.sv ***
// Register command decoder, configuration register and conversion sequencing control
`timescale 1ns/1ps

module arcd_decoder #(
    parameter int LAYERS = 32
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic                  software_mode,
    input  wire logic                  self_detect_fail_flag,
    input  wire logic                  cmd_valid,
    input  wire logic [15:0]           cmd_word,
    input  wire logic                  read_strobe,
    output logic [15:0]                read_data,
    output logic                       read_valid,
    output arcd_pkg::arcd_wr_s         ext_write,
    output logic [5:0]                 ext_read_select,
    input  wire logic [8:0]            ext_read_data,
    input  wire logic [15:0]           status_word,
    input  wire logic [15:0]           conv_result_a,
    input  wire logic [15:0]           conv_result_b,
    input  wire logic                  convert_trigger,
    input  wire logic [LAYERS-1:0]     stack_end_mark,
    input  wire logic                  pair_done,
    output logic                       pair_convert,
    output logic [4:0]                 layer_index,
    output logic [2:0]                 oversample_code,
    output logic                       append_status
);
    import arcd_pkg::*;

    arcd_cmd_s cmd;
    arcd_cfg_s cfg, next_cfg;
    arcd_wr_s  next_ext_write;
    logic      sel_stack;
    logic [4:0] sel_low;

    // Command word split into its fields
    // field split
    assign cmd       = arcd_cmd_s'(cmd_word);
    assign sel_stack = cmd_word[CMD_STACK_BIT];
    assign sel_low   = cmd.register_select[4:0];

    // Effective configuration: every option acts as off outside software mode; register readback shows the stored cfg
    arcd_cfg_s eff;
    assign eff = software_mode ? cfg : arcd_cfg_s'(0);

    // Configuration write decode
    always_comb begin
        next_cfg = cfg;
        if (cmd_valid && cmd.write_not_read && cmd.register_select == ADDR_ACQUISITION_CONFIG) begin
            next_cfg.burst_enable_bit       = cmd.data[CFG_BURST_BIT];
            next_cfg.sequencer_enable_bit   = cmd.data[CFG_SEQ_BIT];
            next_cfg.oversample_ratio       = cmd.data[CFG_OS_HI:CFG_OS_LO];
            next_cfg.status_append_enable   = cmd.data[CFG_STAT_BIT];
            next_cfg.checksum_append_enable = cmd.data[CFG_CRC_BIT];
        end
    end

    // Writes to registers held outside: channel, ranges and stack
    always_comb begin
        next_ext_write                 = '0;
        next_ext_write.register_select = cmd.register_select;
        next_ext_write.data            = cmd.data;
        if (cmd_valid && cmd.write_not_read) begin
            if (sel_stack) begin
                next_ext_write.valid = 1'b1;
            end else if (sel_low >= SEL_CHANNEL && sel_low <= SEL_RANGE_LAST) begin
                next_ext_write.valid = 1'b1;
            end
        end
    end

    // Configuration and forwarded write registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg       <= arcd_cfg_s'(CONFIG_RESET[6:0]);
            ext_write <= '0;
        end else if (clk_en) begin
            cfg       <= next_cfg;
            ext_write <= next_ext_write;
        end
    end

    // Readout: pending register select and conversion word phase
    arcd_rd_e   rd_state, next_rd_state;
    logic [5:0] rd_sel, next_rd_sel;
    logic [15:0] next_read_data;
    logic       next_read_valid;
    logic [8:0] cfg_view;

    // Readable view of configuration, flag bit live from the self-test logic
    // read-only flag
    assign cfg_view = {1'b0, self_detect_fail_flag, cfg};
    assign ext_read_select = rd_sel;

    always_comb begin
        next_rd_state   = rd_state;
        next_rd_sel     = rd_sel;
        next_read_data  = read_data;
        next_read_valid = 1'b0;
        // A read operation is served first, then a new command may redirect the next one
        if (read_strobe) begin
            next_read_valid = 1'b1;
            unique case (rd_state)
                ARCD_RD_REG: begin
                    if (rd_sel == ADDR_ACQUISITION_CONFIG) begin
                        next_read_data = {1'b0, rd_sel, cfg_view};
                    end else if (rd_sel == {1'b0, SEL_STATUS}) begin
                        next_read_data = status_word;
                    end else if (rd_sel[5] || (rd_sel[4:0] >= SEL_CHANNEL && rd_sel[4:0] <= SEL_RANGE_LAST)) begin
                        next_read_data = {1'b0, rd_sel, ext_read_data};
                    end else begin
                        next_read_data = {1'b0, rd_sel, 9'h000};
                    end
                end
                ARCD_RD_CONV_A: begin
                    next_read_data = conv_result_a;
                    next_rd_state  = ARCD_RD_CONV_B;
                end
                ARCD_RD_CONV_B: begin
                    next_read_data = conv_result_b;
                    next_rd_state  = (eff.status_append_enable || eff.checksum_append_enable) ?
                                     ARCD_RD_STATUS : ARCD_RD_CONV_A;
                end
                ARCD_RD_STATUS: begin
                    next_read_data = status_word;
                    next_rd_state  = ARCD_RD_CONV_A;
                end
            endcase
        end
        if (cmd_valid && !cmd.write_not_read) begin
            next_rd_sel = cmd.register_select;
            if (sel_low == SEL_CONV && !sel_stack) begin
                next_rd_state = ARCD_RD_CONV_A;
            end else begin
                next_rd_state = ARCD_RD_REG;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_state   <= ARCD_RD_CONV_A;
            rd_sel     <= '0;
            read_data  <= '0;
            read_valid <= 1'b0;
        end else if (clk_en) begin
            rd_state   <= next_rd_state;
            rd_sel     <= next_rd_sel;
            read_data  <= next_read_data;
            read_valid <= next_read_valid;
        end
    end

    // Convert trigger comes from a pin: two flip-flops before any logic reads it
    logic trig_meta, trig_sync, trig_last;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
        end else if (clk_en) begin
            trig_meta <= convert_trigger;
            trig_sync <= trig_meta;
            trig_last <= trig_sync;
        end
    end

    logic trig_rise;
    assign trig_rise = trig_sync && !trig_last;

    // Sequencer: one pair per trigger, or a whole stack pass when burst and sequencer are both enabled
    arcd_seq_e  seq_state, next_seq_state;
    logic [4:0] next_layer;
    logic       next_pair_convert;
    logic       at_end;

    assign at_end = stack_end_mark[layer_index] || layer_index == 5'(LAYERS - 1);

    always_comb begin
        next_seq_state    = seq_state;
        next_layer        = layer_index;
        next_pair_convert = 1'b0;
        unique case (seq_state)
            ARCD_SEQ_IDLE: begin
                if (trig_rise) begin
                    next_pair_convert = 1'b1;
                    next_seq_state    = ARCD_SEQ_CONVERT;
                end
                if (!eff.sequencer_enable_bit) begin
                    next_layer = '0;
                end
            end
            ARCD_SEQ_CONVERT: begin
                if (pair_done) begin
                    next_seq_state = ARCD_SEQ_IDLE;
                    if (eff.sequencer_enable_bit) begin
                        next_layer = at_end ? 5'h00 : layer_index + 5'h01;
                        if (eff.burst_enable_bit && !at_end) begin
                            next_pair_convert = 1'b1;
                            next_seq_state    = ARCD_SEQ_CONVERT;
                        end
                    end
                end
            end
            default: next_seq_state = ARCD_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seq_state    <= ARCD_SEQ_IDLE;
            layer_index  <= '0;
            pair_convert <= 1'b0;
        end else if (clk_en) begin
            seq_state    <= next_seq_state;
            layer_index  <= next_layer;
            pair_convert <= next_pair_convert;
        end
    end

    // Oversampling code and append flag to the conversion and readout logic
    // ratio code out
    assign oversample_code = eff.oversample_ratio;
    assign append_status   = eff.status_append_enable || eff.checksum_append_enable;

endmodule

// *** arcd_monitor.sv ***
// Concurrent checks on the register command decoder ports
`timescale 1ns/1ps
module arcd_monitor
    import arcd_pkg::*;
#(
    parameter int LAYERS = 32
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        software_mode,
    input wire logic        self_detect_fail_flag,
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic        read_strobe,
    input wire logic [15:0] read_data,
    input wire logic        read_valid,
    input wire arcd_wr_s    ext_write,
    input wire logic [2:0]  oversample_code,
    input wire logic        append_status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Writes that go on to outside storage: channel, range and stack
    logic fwd;
    assign fwd = cmd_valid && clk_en && cmd_word[15]
        && (cmd_word[14] || cmd_word[13:9] inside {[5'h03:5'h07]});
    sequence cfg_wr;
        cmd_valid && clk_en && cmd_word[15:9] == 7'h42;
    endsequence
    sequence cfg_rd;
        cmd_valid && clk_en && cmd_word[15:9] == 7'h02;
    endsequence
    // Status returns raw, so it has no address field to check
    sequence reg_rd;
        cmd_valid && clk_en && !cmd_word[15] && cmd_word[13:9] != 5'h00
            && cmd_word[14:9] != 6'h08;
    endsequence
    // Read operation taken two edges after the request
    sequence rd_go;
        read_strobe && clk_en;
    endsequence

    // A frozen edge holds read_valid, so only enabled edges are judged
    rd_answer_a: assert property (clk_en |=> read_valid == $past(read_strobe))
        else $error("read_valid does not follow read_strobe");
    os_follow_a: assert property (cfg_wr ##1 software_mode |->
        oversample_code == $past(cmd_word[4:2])) else $error("oversample code wrong");
    append_either_a: assert property (cfg_wr ##1 software_mode |->
        append_status == |$past(cmd_word[1:0])) else $error("append enable wrong");
    mode_gate_a: assert property (!software_mode |->
        oversample_code == 3'h0 && !append_status) else $error("options live off mode");
    fwd_write_a: assert property (fwd |=> ext_write.valid
        && ext_write.register_select == $past(cmd_word[14:9])
        && ext_write.data == $past(cmd_word[8:0])) else $error("write not forwarded");
    drop_write_a: assert property (clk_en && !fwd |=> !ext_write.valid)
        else $error("unexpected forwarded write");
    reg_rdback_a: assert property (reg_rd ##2 rd_go |=>
        read_data[15:9] == {1'b0, $past(cmd_word[14:9], 3)}) else $error("address field wrong");
    flag_live_a: assert property (cfg_rd ##2 rd_go |=>
        read_data[7] == $past(self_detect_fail_flag)) else $error("self detect bit wrong");
endmodule

bind arcd_decoder arcd_monitor #(.LAYERS(LAYERS)) mon (.sys_clk, .reset, .clk_en,
    .software_mode, .self_detect_fail_flag, .cmd_valid, .cmd_word, .read_strobe,
    .read_data, .read_valid, .ext_write, .oversample_code, .append_status);

// *** arcd_far_model.sv ***
// Far-side storage and pair converter model facing the decoder
`timescale 1ns/1ps
module arcd_far_model (
    input  wire logic         sys_clk,
    input  wire arcd_pkg::arcd_wr_s ext_write,
    input  wire logic [5:0]   ext_read_select,
    output logic [8:0]        ext_read_data,
    input  wire logic         pair_convert,
    output logic              pair_done
);
    import arcd_pkg::*;
    // Cleared storage so readback never sees unknowns
    logic [8:0] mem [64] = '{default: 9'h000};
    int         busy = 0;
    always @(posedge sys_clk) begin
        if (ext_write.valid) begin
            mem[ext_write.register_select] <= ext_write.data;
        end
    end
    assign ext_read_data = mem[ext_read_select];
    // A pair takes four cycles, so done comes as a late pulse
    always @(posedge sys_clk) begin
        pair_done <= (busy == 1);
        if (pair_convert) begin
            busy <= 4;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
    end
endmodule

// *** adc_register_command_decoder_test.sv ***
// Self-checking bench for the register command decoder
`timescale 1ns/1ps
module adc_register_command_decoder_test;
    import arcd_pkg::*;
    localparam logic [15:0] CA = 16'h1234;
    localparam logic [15:0] CB = 16'h5678;
    localparam logic [15:0] ST = 16'h9abc;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic        sw_mode = 1'b1;
    logic        sdf = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic        read_strobe = 1'b0;
    logic        trig = 1'b0;
    logic [31:0] end_mark = 32'h00000004;
    logic [15:0] read_data;
    logic        read_valid;
    arcd_wr_s    ext_write;
    logic [5:0]  rsel;
    logic [8:0]  rdata;
    logic        pair_convert;
    logic        pair_done;
    logic [4:0]  layer_index;
    logic [2:0]  os_code;
    logic        append;
    logic [15:0] d;
    logic [5:0]  sels [7] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h20, 6'h3f};
    logic [15:0] conv [4] = '{CA, CB, ST, CA};
    logic [4:0]  last_layer = 5'h00;
    int          pairs = 0;
    int          num_errors = 0;
    int          checks_done = 0;

    always #25 sys_clk = ~sys_clk;

    arcd_decoder dut (.sys_clk, .reset, .clk_en, .software_mode(sw_mode),
        .self_detect_fail_flag(sdf), .cmd_valid, .cmd_word, .read_strobe, .read_data,
        .read_valid, .ext_write, .ext_read_select(rsel), .ext_read_data(rdata),
        .status_word(ST), .conv_result_a(CA), .conv_result_b(CB),
        .convert_trigger(trig), .stack_end_mark(end_mark), .pair_done, .pair_convert,
        .layer_index, .oversample_code(os_code), .append_status(append));

    arcd_far_model far (.sys_clk, .ext_write, .ext_read_select(rsel),
        .ext_read_data(rdata), .pair_convert, .pair_done);

    // Count started pairs and remember the layer of the last one
    always @(posedge sys_clk) begin
        if (pair_convert) begin
            pairs <= pairs + 1;
            last_layer <= layer_index;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input logic [15:0] w);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask
    task rd(output logic [15:0] v);
        @(posedge sys_clk);
        read_strobe <= 1'b1;
        @(posedge sys_clk);
        read_strobe <= 1'b0;
        #1;
        chk(16'(read_valid), 16'h0001);
        v = read_data;
    endtask
    // Read request and readback; the strobe always follows two edges later
    task rd_sel(input logic [5:0] s, input logic [15:0] exp);
        cmd({1'b0, s, 9'h000});
        rd(d);
        chk(d, exp);
    endtask
    // Trigger held three cycles so the synchroniser sees one rise
    task trig_count(input int n, input logic [4:0] lay);
        int p0;
        p0 = pairs;
        @(posedge sys_clk) trig <= 1'b1;
        repeat (3) @(posedge sys_clk);
        trig <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk(16'(pairs - p0), 16'(n));
        chk(16'(last_layer), 16'(lay));
    endtask
    task end_of_test;
        $display("Totals: %0d checks, %0d mismatches", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd_sel(6'h02, 16'h0400);
        @(posedge sys_clk) sdf <= 1'b1;
        cmd(16'h85ff);
        rd_sel(6'h02, 16'h04ff);
        $display("test reset and flag done");
        for (int i = 0; i < 8; i++) begin
            cmd(16'h8400 | 16'((i << 2) | (i & 3)));
            #1;
            chk(16'(os_code), 16'(i));
            chk(16'(append), 16'((i & 3) != 0));
        end
        @(posedge sys_clk) sw_mode <= 1'b0;
        #1;
        chk({13'h0000, os_code}, 16'h0000);
        chk(16'(append), 16'h0000);
        @(posedge sys_clk) sw_mode <= 1'b1;
        cmd(16'h83ff);
        cmd(16'h91ff);
        rd_sel(6'h02, 16'h049f);
        $display("test config fields done");
        foreach (sels[k]) begin
            cmd({1'b1, sels[k], 9'h0a5 ^ {3'h0, sels[k]}});
            rd_sel(sels[k], {1'b0, sels[k], 9'h0a5 ^ {3'h0, sels[k]}});
        end
        rd_sel(6'h01, 16'h0200);
        rd_sel(6'h08, ST);
        $display("test registers done");
        cmd(16'h0000);
        foreach (conv[k]) begin
            rd(d);
            chk(d, conv[k]);
        end
        $display("test conversion readout done");
        cmd(16'h8460);
        trig_count(3, 5'h02);
        cmd(16'h8420);
        trig_count(1, 5'h00);
        trig_count(1, 5'h01);
        cmd(16'h8400);
        trig_count(1, 5'h00);
        $display("test sequencer done");
        // Append off: readout wraps from B straight back to A
        cmd(16'h0000);
        rd(d);
        chk(d, CA);
        rd(d);
        chk(d, CB);
        rd(d);
        chk(d, CA);
        // A command seen while the enable is low must leave no trace
        @(posedge sys_clk) clk_en <= 1'b0;
        cmd(16'h841c);
        @(posedge sys_clk) clk_en <= 1'b1;
        #1;
        chk({13'h0000, os_code}, 16'h0000);
        // Mid-run reset clears a loaded configuration
        cmd(16'h847f);
        @(posedge sys_clk) reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({13'h0000, os_code}, 16'h0000);
        rd_sel(6'h02, 16'h0480);
        $display("test enable and reset done");
        end_of_test;
    end

    // Watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        $display("FAIL at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule
